/* core/dtc_pkg.sv */
// dual timer/counter: register offsets, field positions, reset values, modes.
// assumes a single processor clock domain and byte-wide register access.
package dtc_pkg;

  // --------------------------------------------------------------------------
  // register offsets on the special register port
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_RUN_CONTROL = 8'h88;  // flags and run bits
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89;  // gate, select, mode
  localparam logic [7:0] ADDR_TIMER0_COUNT_LOW  = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_COUNT_LOW  = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8D;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int OVF_CH1_BIT  = 7;  // run control: overflow flag ch1
  localparam int RUN_CH1_BIT  = 6;  // run control: run bit ch1
  localparam int OVF_CH0_BIT  = 5;  // run control: overflow flag ch0
  localparam int RUN_CH0_BIT  = 4;  // run control: run bit ch0
  localparam int GATE_CH1_BIT = 7;  // mode select: gate enable ch1
  localparam int SEL_CH1_BIT  = 6;  // mode select: 1 counter, 0 timer, ch1
  localparam int MODE_CH1_LSB = 4;  // mode select: mode field ch1 [5:4]
  localparam int GATE_CH0_BIT = 3;
  localparam int SEL_CH0_BIT  = 2;
  localparam int MODE_CH0_LSB = 0;  // mode field ch0 [1:0]
  localparam int MODE_LOW_ZERO_MSB = 7;  // 13-bit mode: low byte bits 7..5 held zero
  localparam int MODE_LOW_ZERO_LSB = 5;

  // --------------------------------------------------------------------------
  // reset values and timing
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam int         CLK_PERIOD_NS   = 8;   // processor clock, 125 MHz
  localparam int         MCYCLE_CLKS     = 12;  // processor clocks per machine cycle

  // --------------------------------------------------------------------------
  // channel modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } dtc_mode_type;

endpackage

/* core/dtc_top.sv */
// dual timer/counter channels with their control, mode and count registers.
// assumes the core's byte register port, count and gate pins synchronous to CLK_I.
//
// Notes on behaviour
// - two channels, each 16-bit, low and high byte
// - timer mode counts once per twelve clocks
// - counter mode counts falling edges of own input
// - edge seen over two machine-cycle samples
// - run bits 6 and 4 enable channels
// - two-bit mode field selects four modes
// - mode 0: 13 bits, low byte top zero
// - mode 2: low byte reloads from high
// - channel 1 in mode 3 holds its count
// - channel 0 mode 3: two 8-bit counters
// - split high byte uses ch1 run, flag
// - overflow sets flag; software or ack clears
// - select bit: 1 counter, 0 timer
// - gate bit adds external pin to run
module dtc_top #(
  parameter int MCYCLE_CLKS_P = dtc_pkg::MCYCLE_CLKS  // clocks per machine cycle
) (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       ARST_N_I,
  // special register port
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic       SFR_WE_I,
  input  wire logic [7:0] SFR_WDATA_I,
  output logic      [7:0] SFR_RDATA_O,
  // external count and gate pins
  input  wire logic       COUNT_INPUT_CH0_I,
  input  wire logic       COUNT_INPUT_CH1_I,
  input  wire logic       GATE_PIN_CH0_I,
  input  wire logic       GATE_PIN_CH1_I,
  // overflow flags to the interrupt controller and its acknowledges
  input  wire logic       OVF_ACK_CH0_I,
  input  wire logic       OVF_ACK_CH1_I,
  output logic            OVERFLOW_FLAG_CH0_O,
  output logic            OVERFLOW_FLAG_CH1_O
);
  import dtc_pkg::*;

  localparam int PW = $clog2(MCYCLE_CLKS_P);
  localparam logic [PW-1:0] PRE_LAST = PW'(MCYCLE_CLKS_P - 1);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_q;  // two-stage release of the async reset
  logic       rst_n;       // reset copy used everywhere else

  // async assert, clocked release
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [PW-1:0] pre_q, pre_d;        // machine-cycle prescaler
  logic          tick_q, tick_d;      // one-cycle machine-cycle enable
  logic [1:0]    samp_q, samp_d;      // count pins, sampled once per machine cycle
  logic [7:0]    ctl_q, ctl_d;        // timer_run_control
  logic [7:0]    mod_q, mod_d;        // timer_mode_select
  logic [7:0]    lo0_q, lo0_d;        // timer0_count_low
  logic [7:0]    hi0_q, hi0_d;        // timer0_count_high
  logic [7:0]    lo1_q, lo1_d;        // timer1_count_low
  logic [7:0]    hi1_q, hi1_d;        // timer1_count_high
  logic [7:0]    rdata_q, rdata_d;    // registered read data
  // helper terms
  logic [1:0]    ev;                  // count event per channel
  logic [1:0]    run;                 // run and gate combined per channel
  logic          set0, set1;          // hardware overflow this cycle
  dtc_mode_type  mode0, mode1;
  logic [16:0]   st0, st1;            // step results {ovf, high, low}
  logic [8:0]    hsum;                // split-mode high byte sum

  assign mode0 = dtc_mode_type'(mod_q[MODE_CH0_LSB +: 2]);
  assign mode1 = dtc_mode_type'(mod_q[MODE_CH1_LSB +: 2]);

  // one increment step of a channel in its mode
  function automatic logic [16:0] step(input dtc_mode_type m, input logic [7:0] hi, input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    s13 = 14'h0000;
    s16 = 17'h00000;
    case (m)
      MODE_13BIT: begin
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        step = {s13[13], s13[12:5], 3'b000, s13[4:0]};
      end
      MODE_16BIT: begin
        s16 = {1'b0, hi, lo} + 17'h00001;
        step = s16;
      end
      MODE_RELOAD: begin  // reload comes from the unchanged high byte
        step = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      end
      MODE_SPLIT: begin  // low byte alone, high byte untouched here
        step = {(lo == 8'hFF), hi, lo + 8'h01};
      end
      default: begin
        step = {1'b0, hi, lo};
      end
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // count events
  // --------------------------------------------------------------------------
  // pin reads only at machine-cycle ticks, so a level shorter than one
  // machine cycle may be missed entirely; the source must respect that
  always_comb begin
    run[0] = ctl_q[RUN_CH0_BIT] & (~mod_q[GATE_CH0_BIT] | GATE_PIN_CH0_I);
    run[1] = ctl_q[RUN_CH1_BIT] & (~mod_q[GATE_CH1_BIT] | GATE_PIN_CH1_I);
    // falling edge = high at last sample, low now: two machine cycles
    ev[0] = tick_q & (mod_q[SEL_CH0_BIT] ? (samp_q[0] & ~COUNT_INPUT_CH0_I) : 1'b1);
    ev[1] = tick_q & (mod_q[SEL_CH1_BIT] ? (samp_q[1] & ~COUNT_INPUT_CH1_I) : 1'b1);
  end

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    pre_d  = (pre_q == PRE_LAST) ? '0 : pre_q + PW'(1);
    tick_d = (pre_q == PRE_LAST);
    samp_d = tick_q ? {COUNT_INPUT_CH1_I, COUNT_INPUT_CH0_I} : samp_q;
    ctl_d  = ctl_q;
    mod_d  = mod_q;
    lo0_d  = lo0_q;
    hi0_d  = hi0_q;
    lo1_d  = lo1_q;
    hi1_d  = hi1_q;
    set0   = 1'b0;
    set1   = 1'b0;
    st0    = step(mode0, hi0_q, lo0_q);
    st1    = step(mode1, hi1_q, lo1_q);
    hsum   = {1'b0, hi0_q} + 9'h001;
    // channel 0, or its low byte in split mode
    if (ev[0] && run[0]) begin
      {set0, hi0_d, lo0_d} = st0;
    end
    // split mode: high byte is a timer run by the ch1 run bit
    if (mode0 == MODE_SPLIT && tick_q && ctl_q[RUN_CH1_BIT]) begin
      hi0_d = hsum[7:0];
      set1  = hsum[8];
    end
    // channel 1 holds in mode 3; its flag belongs to ch0 high when split
    if (mode1 != MODE_SPLIT && ev[1] && run[1]) begin
      hi1_d = st1[15:8];
      lo1_d = st1[7:0];
      if (mode0 != MODE_SPLIT) begin
        set1 = st1[16];
      end
    end
    // software writes win over the increment of the same cycle
    if (SFR_WE_I) begin
      case (SFR_ADDR_I)
        ADDR_TIMER_RUN_CONTROL: ctl_d = SFR_WDATA_I;
        ADDR_TIMER_MODE_SELECT: mod_d = SFR_WDATA_I;
        ADDR_TIMER0_COUNT_LOW:  lo0_d = SFR_WDATA_I;
        ADDR_TIMER1_COUNT_LOW:  lo1_d = SFR_WDATA_I;
        ADDR_TIMER0_COUNT_HIGH: hi0_d = SFR_WDATA_I;
        ADDR_TIMER1_COUNT_HIGH: hi1_d = SFR_WDATA_I;
        default: ;  // unmapped: ignored
      endcase
    end
    // flags: ack clears, hardware set wins over any clear
    if (OVF_ACK_CH0_I) begin
      ctl_d[OVF_CH0_BIT] = 1'b0;
    end
    if (OVF_ACK_CH1_I) begin
      ctl_d[OVF_CH1_BIT] = 1'b0;
    end
    ctl_d[OVF_CH0_BIT] = ctl_d[OVF_CH0_BIT] | set0;
    ctl_d[OVF_CH1_BIT] = ctl_d[OVF_CH1_BIT] | set1;
    // read mux, registered; unmapped reads zero
    case (SFR_ADDR_I)
      ADDR_TIMER_RUN_CONTROL: rdata_d = ctl_q;
      ADDR_TIMER_MODE_SELECT: rdata_d = mod_q;
      ADDR_TIMER0_COUNT_LOW:  rdata_d = lo0_q;
      ADDR_TIMER1_COUNT_LOW:  rdata_d = lo1_q;
      ADDR_TIMER0_COUNT_HIGH: rdata_d = hi0_q;
      ADDR_TIMER1_COUNT_HIGH: rdata_d = hi1_q;
      default:                rdata_d = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pre_q   <= '0;
      tick_q  <= 1'b0;
      samp_q  <= 2'b00;
      ctl_q   <= REG_RESET_VALUE;
      mod_q   <= REG_RESET_VALUE;
      lo0_q   <= REG_RESET_VALUE;
      hi0_q   <= REG_RESET_VALUE;
      lo1_q   <= REG_RESET_VALUE;
      hi1_q   <= REG_RESET_VALUE;
      rdata_q <= REG_RESET_VALUE;
    end else begin
      pre_q   <= pre_d;
      tick_q  <= tick_d;
      samp_q  <= samp_d;
      ctl_q   <= ctl_d;
      mod_q   <= mod_d;
      lo0_q   <= lo0_d;
      hi0_q   <= hi0_d;
      lo1_q   <= lo1_d;
      hi1_q   <= hi1_d;
      rdata_q <= rdata_d;
    end
  end

  assign SFR_RDATA_O         = rdata_q;
  assign OVERFLOW_FLAG_CH0_O = ctl_q[OVF_CH0_BIT];
  assign OVERFLOW_FLAG_CH1_O = ctl_q[OVF_CH1_BIT];

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  logic wr_t0, wr_t1;  // any software write to a channel's count bytes
  assign wr_t0 = SFR_WE_I && (SFR_ADDR_I == ADDR_TIMER0_COUNT_LOW || SFR_ADDR_I == ADDR_TIMER0_COUNT_HIGH);
  assign wr_t1 = SFR_WE_I && (SFR_ADDR_I == ADDR_TIMER1_COUNT_LOW || SFR_ADDR_I == ADDR_TIMER1_COUNT_HIGH);

  AST_TICK_SPACING: assert property (tick_q |=> !tick_q [*8])
    else $error("machine cycle tick came too soon");
  AST_TIMER16_INC: assert property (
      mode0 == MODE_16BIT && !mod_q[SEL_CH0_BIT] && tick_q && run[0] && !wr_t0
      |=> {hi0_q, lo0_q} == $past({hi0_q, lo0_q}) + 16'h0001)
    else $error("16-bit timer did not step by one");
  AST_RUN_OFF_HOLD: assert property (
      !ctl_q[RUN_CH0_BIT] && mode0 != MODE_SPLIT && !wr_t0 |=> $stable({hi0_q, lo0_q}))
    else $error("stopped channel 0 changed");
  AST_MODE13_TOP_ZERO: assert property (
      mode1 == MODE_13BIT && ev[1] && run[1] && !wr_t1 |=> lo1_q[MODE_LOW_ZERO_MSB:MODE_LOW_ZERO_LSB] == 3'b000)
    else $error("13-bit low byte top bits not zero");
  AST_RELOAD: assert property (
      mode0 == MODE_RELOAD && ev[0] && run[0] && lo0_q == 8'hFF && !wr_t0
      |=> lo0_q == $past(hi0_q) && OVERFLOW_FLAG_CH0_O)
    else $error("auto-reload missed value or flag");
  AST_CH1_SPLIT_HOLD: assert property (mode1 == MODE_SPLIT && !wr_t1 |=> $stable({hi1_q, lo1_q}))
    else $error("channel 1 moved in mode 3");
  AST_SPLIT_HIGH_FLAG: assert property (
      mode0 == MODE_SPLIT && tick_q && ctl_q[RUN_CH1_BIT] && hi0_q == 8'hFF && !wr_t0
      |=> hi0_q == 8'h00 && OVERFLOW_FLAG_CH1_O)
    else $error("split high byte overflow lost");
  AST_COUNTER_NO_EDGE: assert property (
      mod_q[SEL_CH0_BIT] && mode0 == MODE_16BIT && !(samp_q[0] && !COUNT_INPUT_CH0_I) && !wr_t0
      |=> $stable({hi0_q, lo0_q}))
    else $error("counter moved without a falling edge");
  AST_WRAP_FLAG: assert property (
      mode1 == MODE_16BIT && ev[1] && run[1] && {hi1_q, lo1_q} == 16'hFFFF && !wr_t1
      |=> {hi1_q, lo1_q} == 16'h0000 && OVERFLOW_FLAG_CH1_O)
    else $error("16-bit wrap did not zero and flag");
  AST_SET_BEATS_ACK: assert property (set0 |=> OVERFLOW_FLAG_CH0_O)
    else $error("overflow lost against a clear");
  AST_WRITE_WINS: assert property (
      SFR_WE_I && SFR_ADDR_I == ADDR_TIMER0_COUNT_LOW |=> lo0_q == $past(SFR_WDATA_I))
    else $error("count write did not take effect");

  COV_RELOAD:  cover property (mode0 == MODE_RELOAD && set0);
  COV_SPLIT:   cover property (mode0 == MODE_SPLIT && set0 ##[1:1000] set1);
  COV_COUNTER: cover property (mod_q[SEL_CH1_BIT] && ev[1] && run[1]);
  COV_GATED:   cover property (mod_q[GATE_CH0_BIT] && ctl_q[RUN_CH0_BIT] && !GATE_PIN_CH0_I && tick_q);

endmodule

/* verif/dtc_pulse_src.sv */
// count pin source: emits a burst of falling edges on its one count pin.
// assumes the bench clock and an active-low reset; pins idle high.
module dtc_pulse_src #(
  parameter int HOLD_CLKS = 12  // clocks each level is held
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // burst request
  input  wire logic       start_i,
  input  wire logic [7:0] pulses_i,
  // pin and status
  output logic            count_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] left_q;  // level changes still to make
  logic [7:0] hold_q;  // clocks left on current level
  assign busy_o = (left_q != 9'h000) || (hold_q != 8'h00);
  // every level stands a full machine cycle or more
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_q  <= 9'h000;
      hold_q  <= 8'h00;
      count_o <= 1'b1;  // idle high, so no stray edge
    end else if (start_i) begin
      left_q <= {pulses_i, 1'b0};
      hold_q <= 8'(HOLD_CLKS - 1);
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end else if (left_q != 9'h000) begin
      count_o <= ~count_o;  // ends high after an even count
      left_q  <= left_q - 9'h001;
      hold_q  <= 8'(HOLD_CLKS - 1);
    end
  end
endmodule

/* verif/testbench.sv */
// self-checking bench for the dual timer/counter.
// assumes the register port of the top module and one pin source model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dtc_pkg::*;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic       we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       cnt_pin0;
  logic       cnt_pin1;
  logic       gate0 = 1'b0;
  logic       gate1 = 1'b0;
  logic       ack0 = 1'b0;
  logic       ack1 = 1'b0;
  logic       ovf0;
  logic       ovf1;
  logic       pstart = 1'b0;
  logic [7:0] npulses0 = 8'h00;
  logic [7:0] npulses1 = 8'h00;
  logic       pbusy0;
  logic       pbusy1;
  int         fail_count = 0;
  int         samples_checked = 0;
  // --------------------------------------------------------------------------
  // design and pin source
  // --------------------------------------------------------------------------
  dtc_top #(.MCYCLE_CLKS_P(MCYCLE_CLKS)) uut (
    .CLK_I(clk), .ARST_N_I(arst_n), .SFR_ADDR_I(addr), .SFR_WE_I(we), .SFR_WDATA_I(wdata),
    .SFR_RDATA_O(rdata), .COUNT_INPUT_CH0_I(cnt_pin0), .COUNT_INPUT_CH1_I(cnt_pin1),
    .GATE_PIN_CH0_I(gate0), .GATE_PIN_CH1_I(gate1), .OVF_ACK_CH0_I(ack0), .OVF_ACK_CH1_I(ack1),
    .OVERFLOW_FLAG_CH0_O(ovf0), .OVERFLOW_FLAG_CH1_O(ovf1));
  // one pin source per channel, so a swapped pin shows up as a wrong count
  dtc_pulse_src #(.HOLD_CLKS(MCYCLE_CLKS)) src0 (
    .clk_i(clk), .rst_n_i(arst_n), .start_i(pstart), .pulses_i(npulses0), .count_o(cnt_pin0), .busy_o(pbusy0));
  dtc_pulse_src #(.HOLD_CLKS(MCYCLE_CLKS)) src1 (
    .clk_i(clk), .rst_n_i(arst_n), .start_i(pstart), .pulses_i(npulses1), .count_o(cnt_pin1), .busy_o(pbusy1));
  initial begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  // one-cycle write strobe, released at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // read data is registered: wait one extra edge after the address
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk_byte(n, e, rdata);
  endtask
  task automatic load(input logic [7:0] l0, input logic [7:0] h0, input logic [7:0] l1, input logic [7:0] h1);
    wr(ADDR_TIMER0_COUNT_LOW, l0);
    wr(ADDR_TIMER0_COUNT_HIGH, h0);
    wr(ADDR_TIMER1_COUNT_LOW, l1);
    wr(ADDR_TIMER1_COUNT_HIGH, h1);
  endtask
  // run bits stand exactly 120 clocks once the caller's stop write follows,
  // so exactly ten machine cycles pass; flags are looked at before that
  // write, since writing run control also overwrites the flag bits
  task automatic window(input logic [7:0] on);
    wr(ADDR_TIMER_RUN_CONTROL, on);
    repeat (118) @(posedge clk);
    #1;
  endtask
  task automatic counts(input logic [7:0] l0, input logic [7:0] h0, input logic [7:0] l1, input logic [7:0] h1);
    rd("count_low_ch0", ADDR_TIMER0_COUNT_LOW, l0);
    rd("count_high_ch0", ADDR_TIMER0_COUNT_HIGH, h0);
    rd("count_low_ch1", ADDR_TIMER1_COUNT_LOW, l1);
    rd("count_high_ch1", ADDR_TIMER1_COUNT_HIGH, h1);
  endtask
  task automatic pulses(input logic [7:0] n0, input logic [7:0] n1);
    @(posedge clk);
    pstart   <= 1'b1;
    npulses0 <= n0;
    npulses1 <= n1;
    @(posedge clk);
    pstart <= 1'b0;
    #1;
    while (pbusy0 || pbusy1) @(posedge clk);
    repeat (30) @(posedge clk);
  endtask
  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) rd("reset_value", 8'(ADDR_TIMER_RUN_CONTROL + i), REG_RESET_VALUE);
    wr(8'h90, 8'hFF);
    rd("unmapped", 8'h90, 8'h00);
    // ch0 16-bit and ch1 13-bit timers wrap inside ten machine cycles
    wr(ADDR_TIMER_MODE_SELECT, 8'h01);
    rd("mode_select", ADDR_TIMER_MODE_SELECT, 8'h01);
    load(8'hFB, 8'hFF, 8'h1E, 8'hFF);
    window(8'h50);
    chk_bit("flag_ch0", 1'b1, ovf0);
    chk_bit("flag_ch1", 1'b1, ovf1);
    wr(ADDR_TIMER_RUN_CONTROL, 8'hA0);
    counts(8'h05, 8'h00, 8'h08, 8'h00);
    rd("run_control", ADDR_TIMER_RUN_CONTROL, 8'hA0);
    @(posedge clk);
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit("flag_ch0", 1'b0, ovf0);
    chk_bit("flag_ch1", 1'b1, ovf1);
    wr(ADDR_TIMER_RUN_CONTROL, 8'h00);
    @(posedge clk);
    #1;
    chk_bit("flag_ch1", 1'b0, ovf1);
    // ch0 8-bit reload, ch1 held by its split code
    wr(ADDR_TIMER_MODE_SELECT, 8'h32);
    load(8'hFC, 8'h80, 8'h11, 8'h22);
    window(8'h50);
    chk_bit("flag_ch1", 1'b0, ovf1);
    chk_bit("flag_ch0", 1'b1, ovf0);
    wr(ADDR_TIMER_RUN_CONTROL, 8'h00);
    counts(8'h86, 8'h80, 8'h11, 8'h22);
    // ch0 split into two bytes; high byte follows the ch1 run bit
    wr(ADDR_TIMER_MODE_SELECT, 8'h33);
    load(8'hFE, 8'hF8, 8'h11, 8'h22);
    window(8'h50);
    chk_bit("flag_ch0", 1'b1, ovf0);
    chk_bit("flag_ch1", 1'b1, ovf1);
    wr(ADDR_TIMER_RUN_CONTROL, 8'h00);
    counts(8'h08, 8'h02, 8'h11, 8'h22);
    // low byte alone overflows: only the ch0 flag may rise
    wr(ADDR_TIMER0_COUNT_LOW, 8'hF9);
    window(8'h10);
    chk_bit("flag_ch0", 1'b1, ovf0);
    chk_bit("flag_ch1", 1'b0, ovf1);
    wr(ADDR_TIMER_RUN_CONTROL, 8'h00);
    counts(8'h03, 8'h02, 8'h11, 8'h22);
    // high byte alone overflows: only the ch1 flag may rise
    wr(ADDR_TIMER0_COUNT_HIGH, 8'hFA);
    window(8'h40);
    chk_bit("flag_ch1", 1'b1, ovf1);
    chk_bit("flag_ch0", 1'b0, ovf0);
    wr(ADDR_TIMER_RUN_CONTROL, 8'h00);
    counts(8'h03, 8'h04, 8'h11, 8'h22);
    // counter mode at the fastest pin rate, each channel gated by its own pin
    wr(ADDR_TIMER_MODE_SELECT, 8'hDD);
    load(8'h00, 8'h00, 8'hFF, 8'hFF);
    wr(ADDR_TIMER_RUN_CONTROL, 8'h50);
    @(posedge clk);
    gate1 <= 1'b1;
    pulses(8'h02, 8'h03);
    counts(8'h00, 8'h00, 8'h02, 8'h00);
    chk_bit("flag_ch1", 1'b1, ovf1);
    @(posedge clk);
    gate0 <= 1'b1;
    gate1 <= 1'b0;
    pulses(8'h02, 8'h03);
    counts(8'h02, 8'h00, 8'h02, 8'h00);
    tally_and_finish();
  end
  // watchdog: the whole sequence needs about a thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
